// ==== rtl/frsm_core.sv ====
// Fault reaction state machine: soft reset, escalation and safe shutdown control
`timescale 1ns/1ns
`include "frsm_params.svh"

// Function
// - Fault from sleep/wake: soft reset, outputs on
// - Soft reset re-enables regulators, standby keeps setting
// - Undervoltage: reset delay starts when supplies recover
// - Long undervoltage: startup state, then safe shutdown
// - Watchdog overflow or error pin trigger soft reset
// - Monitor soft reset: delay starts at reset fall
// - Safe state outputs low in sleep and wake; first one also low in startup
// - Internal supply fault forces hard reset instead
// - Regulator and reference faults force safe shutdown
// - Prereg overvoltage/thermal always; short only while sequencing
// - Later prereg short only sets its status flag
// - Third consecutive init failure forces safe shutdown
// - Bias, monitor overtemperature, fuse faults force shutdown
// - Main supply overvoltage forces safe shutdown
// - Startup state: reset low at once on shutdown fault
// - Safe shutdown entry switches every regulator off
// - Undervoltage drops reset and first safe output together
// - Persistent short: flag event, all off, shut down
// - Second safe output low at shutdown, delay ignored
// - Normal overvoltage: shutdown, reset low on detection
// - Normal to shutdown: both safe outputs drop immediately
// - Normal short handled first as undervoltage
// - Priority: power off, then shutdown, then startup
module frsm_core
  import frsm_pkg::*;
#(
  parameter int unsigned NREG       = 5,
  parameter int unsigned TW         = `FRSM_TMR_W,
  parameter int unsigned RD_CYCLES  = `FRSM_RD_CYC,
  parameter int unsigned STG_CYCLES = `FRSM_STG_CYC,
  parameter int unsigned SS2_CYCLES = `FRSM_SS2_CYC
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  // Mode requests, one-cycle pulses
  input  wire logic              req_sleep,
  input  wire logic              req_wake,
  input  wire logic              req_normal,
  input  wire logic              init_done,
  input  wire logic              init_timeout,
  input  wire logic              safe_exit,
  input  wire logic              power_restart,
  // Configuration levels
  input  wire logic [NREG-1:0]   low_power_reg_en,
  input  wire logic              stby_cfg_on,
  input  wire logic              ss_enable,
  // Power sequencing progress
  input  wire logic              seq_done,
  // Microcontroller supply undervoltage, any of the three
  input  wire logic              uv_micro,
  // Monitor events, one-cycle pulses
  input  wire logic              wd_overflow,
  input  wire logic              err_pin_fault,
  // Regulator faults, levels
  input  wire logic              micro_reg_ov,
  input  wire logic              micro_reg_stg,
  input  wire logic              micro_reg_tsd,
  input  wire logic              core_ov,
  input  wire logic              core_stg,
  input  wire logic              stby_ov,
  input  wire logic              stby_stg,
  input  wire logic              vref_ov,
  input  wire logic              prereg_ov,
  input  wire logic              prereg_tsd,
  input  wire logic              prereg_stg,
  // Internal faults, levels
  input  wire logic              bias_fail,
  input  wire logic              mon_thermal_shutdown,
  input  wire logic              fuse_fail,
  input  wire logic              main_supply_ov,
  input  wire logic              main_supply_low,
  input  wire logic              int_supply_fault,
  // Status flag clear, pulse
  input  wire logic              prereg_short_clr,
  // Outputs toward the microcontroller
  output logic                   reset_out,
  output logic                   safe_state_first,
  output logic                   safe_state_second,
  // Regulator enables
  output logic [NREG-1:0]        main_reg_en,
  output logic                   stby_reg_en,
  // Status
  output frsm_pkg::frsm_state_t  state,
  output logic                   short_event,
  output logic                   hard_reset,
  output logic                   prereg_short_flag
);

  import frsm_pkg::*;

  frsm_state_t    next_state;
  frsm_fail_cnt_t fail_cnt;
  logic           uv_q;
  logic           rd_wait;
  logic           seq_phase;

  frsm_tmr_if #(.TW(TW)) rd_tmr ();
  frsm_tmr_if #(.TW(TW)) stg_tmr ();
  frsm_tmr_if #(.TW(TW)) ss2_tmr ();

  frsm_timer #(.TW(TW)) u_rd_timer (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .tmr     (rd_tmr)
  );

  frsm_timer #(.TW(TW)) u_stg_timer (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .tmr     (stg_tmr)
  );

  frsm_timer #(.TW(TW)) u_ss2_timer (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .tmr     (ss2_tmr)
  );

  function automatic logic in_state(input frsm_state_t s, input frsm_state_t ref_s);
    in_state = (s == ref_s);
  endfunction : in_state

  // Fault classification
  wire uv_rise       = uv_micro & ~uv_q;
  wire st_init       = in_state(state, FRSM_INIT);
  wire st_normal     = in_state(state, FRSM_NORMAL);
  wire st_low_power  = in_state(state, FRSM_SLEEP) | in_state(state, FRSM_WAKE);
  wire st_safe       = in_state(state, FRSM_SAFE_SHUT);
  wire st_off        = in_state(state, FRSM_POWER_OFF);
  wire third_fail    = st_init & init_timeout & (fail_cnt == `FRSM_FAIL_LIMIT);
  wire retry_fail    = st_init & init_timeout & (fail_cnt != `FRSM_FAIL_LIMIT);
  wire monitor_evt   = wd_overflow | err_pin_fault;

  wire pd_fault      = int_supply_fault | main_supply_low;
  wire reg_fault     = micro_reg_ov | micro_reg_stg | micro_reg_tsd
                     | core_ov | core_stg | stby_ov | stby_stg | vref_ov;
  wire prereg_fault  = prereg_ov | prereg_tsd | (prereg_stg & seq_phase);
  wire intern_fault  = bias_fail | mon_thermal_shutdown | fuse_fail;
  // Standby is not served here, so main supply overvoltage always counts
  wire fs_fault      = reg_fault | prereg_fault | intern_fault | main_supply_ov
                     | third_fail
                     | stg_tmr.expired;
  // Short on a micro supply is seen first as undervoltage
  wire init_evt      = uv_rise | monitor_evt | retry_fail;
  // A late prereg short is only recorded, it never changes state
  wire prereg_late   = prereg_stg & ~seq_phase;

  // Single highest-priority transition per cycle
  always_comb
  begin
    next_state = state;
    if (pd_fault)
      next_state = FRSM_POWER_OFF;
    else if (st_off)
    begin
      if (power_restart)
        next_state = FRSM_INIT;
    end
    else if (fs_fault)
      next_state = FRSM_SAFE_SHUT;
    else if (st_safe)
    begin
      if (safe_exit)
        next_state = FRSM_INIT;
    end
    else if (init_evt)
      next_state = FRSM_INIT;
    else
    begin
      case (state)
        FRSM_INIT:
        begin
          if (init_done && reset_out)
            next_state = FRSM_NORMAL;
        end
        FRSM_NORMAL:
        begin
          if (req_sleep)
            next_state = FRSM_SLEEP;
          else if (req_wake)
            next_state = FRSM_WAKE;
        end
        FRSM_SLEEP, FRSM_WAKE:
        begin
          if (req_normal)
            next_state = FRSM_NORMAL;
        end
        default:
          next_state = FRSM_INIT;
      endcase
    end
  end

  // Entry into the startup state, including a re-entry from itself
  wire go_init       = in_state(next_state, FRSM_INIT) & (~st_init | init_evt);
  wire soft_entry    = go_init & ~st_safe & ~st_off;
  wire go_safe       = in_state(next_state, FRSM_SAFE_SHUT);
  wire go_off        = in_state(next_state, FRSM_POWER_OFF);
  wire go_normal     = in_state(next_state, FRSM_NORMAL);
  wire stays_up      = in_state(next_state, FRSM_INIT) | go_normal;
  wire next_low_pwr  = in_state(next_state, FRSM_SLEEP) | in_state(next_state, FRSM_WAKE);

  // Reset delay: undervoltage waits for recovery, monitor causes start at the fall
  wire rd_cause_uv   = go_init & (uv_micro | rd_wait);
  // A restart from shutdown or power-off has no reset fall to time from, so it waits
  // for the supplies the way power-on does
  wire rd_restart    = go_init & (st_safe | st_off);
  wire rd_now        = soft_entry & ~rd_cause_uv;
  wire rd_recover    = rd_wait & ~uv_micro & ~go_safe & ~go_off;
  assign rd_tmr.start = rd_now | rd_recover;
  assign rd_tmr.clear = go_safe | go_off | (rd_wait & uv_micro);
  assign rd_tmr.load  = TW'(RD_CYCLES);

  // Short detection runs for as long as the undervoltage lasts
  assign stg_tmr.start = uv_rise;
  assign stg_tmr.clear = ~uv_micro | go_safe | go_off;
  assign stg_tmr.load  = TW'(STG_CYCLES);

  // Second safe output falls after its delay when normal drops to startup without undervoltage
  wire ss2_begin     = st_normal & go_init & safe_state_second & ~uv_micro;
  assign ss2_tmr.start = ss2_begin;
  assign ss2_tmr.clear = ~in_state(next_state, FRSM_INIT);
  assign ss2_tmr.load  = TW'(SS2_CYCLES);

  wire ss2_hold      = in_state(next_state, FRSM_INIT) & safe_state_second
                     & (ss2_begin | (ss2_tmr.running & ~ss2_tmr.expired));

  // Output next values
  wire next_reset    = ~(go_safe | go_off
                       | soft_entry
                       | uv_micro)
                     & (reset_out | (st_init & rd_tmr.expired));
  wire next_ss1      = go_normal & ss_enable & ~uv_micro;
  wire next_ss2      = (go_normal & ss_enable) | ss2_hold;

  // Regulators: all main ones in startup and normal, standby per its setting; none in shutdown or power off
  wire [NREG-1:0] next_main_en = stays_up     ? {NREG{1'b1}}
                               : next_low_pwr ? low_power_reg_en
                               : '0;
  wire            next_stby_en = (stays_up | next_low_pwr) & stby_cfg_on;

  // Failure count: retried configurations add up, success clears
  // Shutdown and power-off clear first so a restart gets fresh attempts
  wire [1:0] next_fail = go_normal              ? `FRSM_FAIL_ZERO
                       : (go_safe | go_off)     ? `FRSM_FAIL_ZERO
                       : init_timeout & st_init ? fail_cnt + `FRSM_FAIL_STEP
                       : fail_cnt;

  // Sequencing phase spans startup entry up to the regulators being in range
  wire next_seq      = go_init | (seq_phase & ~seq_done & stays_up);

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      state <= FRSM_INIT;
    else
      state <= next_state;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      reset_out         <= 1'b0;
      safe_state_first  <= 1'b0;
      safe_state_second <= 1'b0;
    end
    else
    begin
      reset_out         <= next_reset;
      safe_state_first  <= next_ss1;
      safe_state_second <= next_ss2;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      main_reg_en <= '0;
      stby_reg_en <= 1'b0;
    end
    else
    begin
      main_reg_en <= next_main_en;
      stby_reg_en <= next_stby_en;
    end
  end

  // Power-on behaves like an undervoltage recovery so the delay runs once supplies are up
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      uv_q      <= 1'b0;
      rd_wait   <= 1'b1;
      seq_phase <= 1'b1;
      fail_cnt  <= `FRSM_FAIL_ZERO;
    end
    else
    begin
      uv_q      <= uv_micro;
      rd_wait   <= (rd_cause_uv | rd_restart | (rd_wait & uv_micro))
                   & ~go_safe & ~go_off;
      seq_phase <= next_seq;
      fail_cnt  <= next_fail;
    end
  end

  // Event pulses
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      short_event <= 1'b0;
      hard_reset  <= 1'b0;
    end
    else
    begin
      short_event <= stg_tmr.expired & ~pd_fault;
      hard_reset  <= int_supply_fault & ~st_off;
    end
  end

  // Set wins over clear; no state change and no interrupt for a late prereg short
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      prereg_short_flag <= 1'b0;
    else if (prereg_late)
      prereg_short_flag <= 1'b1;
    else if (prereg_short_clr)
      prereg_short_flag <= 1'b0;
  end

endmodule : frsm_core

// ==== rtl/frsm_params.svh ====
// Timing constants and limits for the fault reaction state machine
`ifndef FRSM_PARAMS_SVH
`define FRSM_PARAMS_SVH

// System clock rate in MHz (10 ns period)
`define FRSM_CLK_MHZ        100

// Reset delay time in microseconds
`define FRSM_T_RD_US        10
// Short-to-ground detection time in microseconds
`define FRSM_T_STG_US       200
// Second safe state delay in microseconds
`define FRSM_SECOND_SAFE_STATE_DELAY_US       50

// Cycle counts derived from the times above; whole microseconds give exact counts
`define FRSM_RD_CYC         (`FRSM_T_RD_US * `FRSM_CLK_MHZ)
`define FRSM_STG_CYC        (`FRSM_T_STG_US * `FRSM_CLK_MHZ)
`define FRSM_SS2_CYC        (`FRSM_SECOND_SAFE_STATE_DELAY_US * `FRSM_CLK_MHZ)

// Timer counter width
`define FRSM_TMR_W          32
// Initialisation failures already counted when the next one is the third
`define FRSM_FAIL_LIMIT     2'h2
// Increment for the failure counter
`define FRSM_FAIL_STEP      2'h1
// Cleared failure counter
`define FRSM_FAIL_ZERO      2'h0

`endif

// ==== rtl/frsm_pkg.sv ====
// Types shared by the fault reaction state machine
package frsm_pkg;

  typedef enum logic [2:0] {
    FRSM_SLEEP     = 3'h0,
    FRSM_WAKE      = 3'h1,
    FRSM_INIT      = 3'h2,
    FRSM_NORMAL    = 3'h3,
    FRSM_SAFE_SHUT = 3'h4,
    FRSM_POWER_OFF = 3'h5
  } frsm_state_t;

  typedef logic [1:0] frsm_fail_cnt_t;

endpackage : frsm_pkg

// ==== rtl/frsm_tmr_if.sv ====
// Control and status bundle between the state machine and one delay timer
`timescale 1ns/1ns
interface frsm_tmr_if #(
  parameter int unsigned TW = 32
);
  logic          start;
  logic          clear;
  logic [TW-1:0] load;
  logic          running;
  logic          expired;

  modport ctrl (output start, output clear, output load, input running, input expired);
  modport tmr  (input start, input clear, input load, output running, output expired);
endinterface : frsm_tmr_if

// ==== rtl/frsm_timer.sv ====
// One-shot down-counting delay timer
`timescale 1ns/1ns
module frsm_timer #(
  parameter int unsigned TW = 32
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rstn,
  // Control and status
  frsm_tmr_if.tmr   tmr
);

  logic [TW-1:0] cnt;

  wire cnt_last = (cnt == TW'(1));

  assign tmr.running = (cnt != '0);
  assign tmr.expired = cnt_last;

  // Clear beats start so a stale start cannot revive a cancelled delay
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      cnt <= '0;
    else if (tmr.clear)
      cnt <= '0;
    else if (tmr.start)
      cnt <= tmr.load;
    else if (cnt != '0)
      cnt <= cnt - TW'(1);
  end

endmodule : frsm_timer

// ==== verif/frsm_core_monitor.sv ====
// Port-level checks on the fault reaction state machine
`timescale 1ns/1ns
module frsm_core_monitor
  import frsm_pkg::*;
#(
  parameter int unsigned NREG = 5
) (
  // Clock and reset
  input wire logic                  clk_sys,
  input wire logic                  rstn,
  // Causes
  input wire logic                  uv_micro,
  input wire logic                  wd_overflow,
  input wire logic                  err_pin_fault,
  input wire logic                  micro_reg_ov,
  input wire logic                  prereg_stg,
  input wire logic                  seq_done,
  input wire logic                  int_supply_fault,
  input wire logic                  main_supply_low,
  input wire logic                  stby_cfg_on,
  // Reactions
  input wire logic                  reset_out,
  input wire logic                  safe_state_first,
  input wire logic                  safe_state_second,
  input wire logic [NREG-1:0]       main_reg_en,
  input wire logic                  stby_reg_en,
  input wire frsm_pkg::frsm_state_t state,
  input wire logic                  hard_reset,
  input wire logic                  prereg_short_flag
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire pd_flt  = int_supply_fault | main_supply_low;
  wire mon_evt = wd_overflow | err_pin_fault;

  chk_power_off_first: assert property (pd_flt && state != FRSM_POWER_OFF |=>
    state == FRSM_POWER_OFF && hard_reset == $past(int_supply_fault))
    else $error("power-off not taken first");
  chk_uv_drop_pair: assert property ($rose(uv_micro) && !pd_flt && !micro_reg_ov &&
    state == FRSM_NORMAL |=> state == FRSM_INIT && !reset_out && !safe_state_first)
    else $error("undervoltage did not drop reset and first safe output");
  chk_uv_reset_hold: assert property (state == FRSM_INIT && uv_micro |=> !reset_out)
    else $error("reset released during undervoltage");
  chk_uv_delay_end: assert property ($fell(uv_micro) && state == FRSM_INIT && !mon_evt
    |-> !reset_out [*8] ##[1:4] reset_out) else $error("reset delay after recovery wrong");
  chk_monitor_soft: assert property (mon_evt && state inside {FRSM_SLEEP, FRSM_WAKE} &&
    !pd_flt && !micro_reg_ov && !uv_micro |=> state == FRSM_INIT && main_reg_en == '1 &&
    stby_reg_en == stby_cfg_on ##0 !reset_out [*8] ##[1:4] reset_out)
    else $error("monitor soft reset wrong");
  chk_low_power_safe: assert property (state inside {FRSM_SLEEP, FRSM_WAKE} |->
    !safe_state_first && !safe_state_second) else $error("safe outputs high in low power");
  chk_init_first_low: assert property (state == FRSM_INIT |-> !safe_state_first)
    else $error("first safe output high in startup state");
  chk_shut_all_off: assert property (state == FRSM_SAFE_SHUT |-> main_reg_en == '0 &&
    !stby_reg_en && !reset_out && !safe_state_first && !safe_state_second)
    else $error("outputs not off in safe shutdown");
  chk_normal_ov_drop: assert property (state == FRSM_NORMAL && micro_reg_ov && !pd_flt
    |=> state == FRSM_SAFE_SHUT && !reset_out && !safe_state_second)
    else $error("overvoltage in normal not handled");
  chk_prereg_late: assert property (state == FRSM_NORMAL && seq_done && prereg_stg &&
    !pd_flt && !micro_reg_ov && !uv_micro && !mon_evt |=> state != FRSM_SAFE_SHUT &&
    prereg_short_flag) else $error("late prereg short mishandled");
endmodule : frsm_core_monitor

bind frsm_core frsm_core_monitor #(.NREG(NREG)) u_frsm_core_monitor (
  .clk_sys(clk_sys), .rstn(rstn), .uv_micro(uv_micro), .wd_overflow(wd_overflow),
  .err_pin_fault(err_pin_fault), .micro_reg_ov(micro_reg_ov), .prereg_stg(prereg_stg),
  .seq_done(seq_done), .int_supply_fault(int_supply_fault), .main_supply_low(main_supply_low),
  .stby_cfg_on(stby_cfg_on), .reset_out(reset_out), .safe_state_first(safe_state_first),
  .safe_state_second(safe_state_second), .main_reg_en(main_reg_en), .stby_reg_en(stby_reg_en),
  .state(state), .hard_reset(hard_reset), .prereg_short_flag(prereg_short_flag));

// ==== verif/frsm_micro_model.sv ====
// Behavioural microcontroller that configures the device after each reset
`timescale 1ns/1ns
module frsm_micro_model #(
  parameter int unsigned CFG_DLY = 3
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rstn,
  // Device reset and scenario control
  input  wire logic reset_out,
  input  wire logic cfg_fail,
  // Configuration finished
  output logic      init_done
);
  logic [3:0] cnt;
  // One attempt per reset release; a failing setup stays silent so the init timer runs out
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn || !reset_out)
    begin
      cnt       <= 4'h0;
      init_done <= 1'h0;
    end
    else
    begin
      cnt       <= (cnt < 4'(CFG_DLY)) ? cnt + 4'h1 : cnt;
      init_done <= (cnt == 4'(CFG_DLY - 1)) && !cfg_fail;
    end
  end
endmodule : frsm_micro_model

// ==== verif/frsm_core_test.sv ====
// Self-checking bench for the fault reaction state machine
`timescale 1ns/1ns
module frsm_core_test;
  import frsm_pkg::*;
  localparam int unsigned STG = 20;
  logic        clk_sys = 1'h0;
  logic        rstn = 1'h0;
  logic [8:0]  ev = 9'h0;
  logic [17:0] lv = 18'h0;
  logic [4:0]  lp_en = 5'h1f;
  logic        stby_on = 1'h1;
  logic        cfg_fail = 1'h0;
  logic        seq_done = 1'h1;
  logic        init_done, reset_out, ss1, ss2, stby_reg_en, short_event, hard_reset, pflag;
  logic [4:0]  main_reg_en;
  frsm_state_t state;
  int          num_errors = 0;
  int          samples_checked = 0;

  always #5 clk_sys = ~clk_sys;

  // Short counts keep the run brief; the second safe delay outlasts the short timer
  frsm_core #(.RD_CYCLES(8), .STG_CYCLES(STG), .SS2_CYCLES(40)) u_frsm_core (
    .clk_sys(clk_sys), .rstn(rstn), .req_sleep(ev[0]), .req_wake(ev[1]), .req_normal(ev[2]),
    .init_done(init_done), .init_timeout(ev[3]), .safe_exit(ev[4]), .power_restart(ev[5]),
    .low_power_reg_en(lp_en), .stby_cfg_on(stby_on), .ss_enable(1'h1), .seq_done(seq_done),
    .uv_micro(lv[15]), .wd_overflow(ev[6]), .err_pin_fault(ev[7]), .micro_reg_ov(lv[0]),
    .micro_reg_stg(lv[1]), .micro_reg_tsd(lv[2]), .core_ov(lv[3]), .core_stg(lv[4]),
    .stby_ov(lv[5]), .stby_stg(lv[6]), .vref_ov(lv[7]), .prereg_ov(lv[8]), .prereg_tsd(lv[9]),
    .prereg_stg(lv[14]), .bias_fail(lv[10]), .mon_thermal_shutdown(lv[11]), .fuse_fail(lv[12]),
    .main_supply_ov(lv[13]), .main_supply_low(lv[17]), .int_supply_fault(lv[16]),
    .prereg_short_clr(ev[8]), .reset_out(reset_out), .safe_state_first(ss1),
    .safe_state_second(ss2), .main_reg_en(main_reg_en), .stby_reg_en(stby_reg_en),
    .state(state), .short_event(short_event), .hard_reset(hard_reset),
    .prereg_short_flag(pflag));

  frsm_micro_model u_frsm_micro_model (.clk_sys(clk_sys), .rstn(rstn), .reset_out(reset_out),
    .cfg_fail(cfg_fail), .init_done(init_done));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task automatic pulse(input int i);
    @(posedge clk_sys) ev[i] <= 1'h1;
    @(posedge clk_sys) ev <= 9'h0;
    #1;
  endtask : pulse

  task automatic set_lv(input int i, input logic v);
    @(posedge clk_sys) lv[i] <= v;
    @(posedge clk_sys) #1;
  endtask : set_lv

  task automatic wait_state(input frsm_state_t s, output int n);
    n = 0;
    while (state !== s)
    begin
      @(posedge clk_sys) #1;
      n++;
      if (n > 200)
      begin
        chk("wait_state", state, s);
        give_verdict();
      end
    end
  endtask : wait_state

  task automatic t_uv_short;
    int n;
    set_lv(15, 1'h1);
    chk("uv_state", state, FRSM_INIT);
    chk("uv_rst_ss1", {reset_out, ss1}, 2'h0);
    set_lv(15, 1'h0);
    chk("uv_rst_held", reset_out, 1'h0);
    wait_state(FRSM_NORMAL, n);
    chk("uv_release", n > 8, 1'h1);
    $display("test uv_short done");
  endtask : t_uv_short

  task automatic t_low_power;
    int n;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk_sys) lp_en <= 5'h0;
      stby_on <= 1'h0;
      pulse(i);
      chk("lp_state", state, i);
      chk("lp_outs", {main_reg_en, ss1, ss2}, 7'h0);
      pulse(6 + i);
      chk("lp_init", state, FRSM_INIT);
      chk("lp_regs", {main_reg_en, stby_reg_en, reset_out, ss1}, 8'hf8);
      wait_state(FRSM_NORMAL, n);
      chk("lp_delay", n > 8, 1'h1);
    end
    $display("test low_power done");
  endtask : t_low_power

  task automatic t_uv_long;
    int n;
    set_lv(15, 1'h1);
    chk("long_init", {state, ss2}, {FRSM_INIT, 1'h0});
    wait_state(FRSM_SAFE_SHUT, n);
    chk("long_event", short_event, 1'h1);
    chk("long_time", n >= STG - 2, 1'h1);
    chk("long_off", {main_reg_en, stby_reg_en, ss1, ss2, reset_out}, 9'h0);
    set_lv(15, 1'h0);
    pulse(4);
    wait_state(FRSM_NORMAL, n);
    $display("test uv_long done");
  endtask : t_uv_long

  task automatic second_safe_state_delay_cut;
    int n;
    pulse(6);
    chk("ss2_held", {state, ss1, ss2}, {FRSM_INIT, 2'h1});
    set_lv(0, 1'h1);
    chk("ss2_cut", {state, ss2, reset_out}, {FRSM_SAFE_SHUT, 2'h0});
    set_lv(0, 1'h0);
    pulse(4);
    wait_state(FRSM_NORMAL, n);
    $display("test ss2_cut done");
  endtask : second_safe_state_delay_cut

  task automatic t_startup_short;
    int n;
    @(posedge clk_sys) seq_done <= 1'h0;
    cfg_fail <= 1'h1;
    pulse(6);
    repeat (12) @(posedge clk_sys);
    #1;
    chk("seq_rst", {state, reset_out}, {FRSM_INIT, 1'h1});
    set_lv(14, 1'h1);
    chk("seq_short", {state, reset_out, pflag}, {FRSM_SAFE_SHUT, 2'h0});
    @(posedge clk_sys) lv <= 18'h0;
    seq_done <= 1'h1;
    cfg_fail <= 1'h0;
    pulse(4);
    wait_state(FRSM_NORMAL, n);
    $display("test startup_short done");
  endtask : t_startup_short

  task automatic t_shutdown_faults;
    int n;
    for (int j = 0; j < 14; j++)
    begin
      set_lv(j, 1'h1);
      chk("flt_state", state, FRSM_SAFE_SHUT);
      chk("flt_outs", {reset_out, ss1, ss2}, 3'h0);
      set_lv(j, 1'h0);
      pulse(4);
      wait_state(FRSM_NORMAL, n);
    end
    $display("test shutdown_faults done");
  endtask : t_shutdown_faults

  task automatic t_misc;
    int n;
    set_lv(14, 1'h1);
    chk("pre_flag", {state, pflag}, {FRSM_NORMAL, 1'h1});
    set_lv(14, 1'h0);
    pulse(8);
    chk("pre_clear", pflag, 1'h0);
    @(posedge clk_sys) cfg_fail <= 1'h1;
    pulse(6);
    for (int k = 0; k < 3; k++)
    begin
      pulse(3);
      chk("fail_state", state, (k < 2) ? FRSM_INIT : FRSM_SAFE_SHUT);
    end
    @(posedge clk_sys) cfg_fail <= 1'h0;
    pulse(4);
    wait_state(FRSM_NORMAL, n);
    @(posedge clk_sys) lv <= 18'h10001;
    @(posedge clk_sys) #1;
    chk("pd_state", {state, hard_reset}, {FRSM_POWER_OFF, 1'h1});
    @(posedge clk_sys) lv <= 18'h0;
    pulse(5);
    wait_state(FRSM_NORMAL, n);
    $display("test misc done");
  endtask : t_misc

  initial
  begin
    int n;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'h1;
    wait_state(FRSM_NORMAL, n);
    chk("boot_reset", reset_out, 1'h1);
    t_uv_short();
    t_low_power();
    t_uv_long();
    second_safe_state_delay_cut();
    t_shutdown_faults();
    t_misc();
    t_startup_short();
    give_verdict();
  end
endmodule : frsm_core_test
